/* File: rtl/seri_pkg.sv */
// Purpose: shared constants and types for the two-wire memory slave
// Assumes: ref_clk at 125 MHz
// Notes:   density is given in kbit: 1, 2, 4, 8 or 16
package seri_pkg;

   // ======================================================
   // timing
   localparam int          CLK_KHZ   = 125000;               // 8 ns period
   localparam int          T_WR_MS   = 10;                   // longest write cycle
   localparam int          WR_CYCLES = T_WR_MS * CLK_KHZ;    // rounds down, exact here
   localparam logic [1:0]  FILT_LEN  = 2'h2;                 // stable samples needed

   // ======================================================
   // slave address byte layout
   localparam logic [3:0]  TYPE_CODE = 4'ha;                 // fixed device type
   localparam int          SA_TYPE_LO = 4;
   localparam int          SA_SEL_HI  = 3;
   localparam int          SA_SEL_LO  = 1;
   localparam int          SA_RW      = 0;
   localparam logic [3:0]  BYTE_BITS  = 4'h8;
   localparam logic [3:0]  LAST_TX    = 4'h7;
   localparam int          DENSITY_DEFAULT = 2;

   // ======================================================
   // controller states
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_ACK  = 7'h04,
      ST_WRX  = 7'h08,
      ST_TX   = 7'h10,
      ST_MACK = 7'h20,
      ST_WAIT = 7'h40
   } seri_state_t;

   // ======================================================
   // density helpers
   function automatic int addr_width(input int kbit);
      case (kbit)
         1:       addr_width = 7;
         4:       addr_width = 9;
         8:       addr_width = 10;
         16:      addr_width = 11;
         default: addr_width = 8;
      endcase
   endfunction

   // which select bits compare against straps
   function automatic logic [2:0] sel_mask(input int kbit);
      case (kbit)
         4:       sel_mask = 3'h6;
         8:       sel_mask = 3'h4;
         16:      sel_mask = 3'h0;
         default: sel_mask = 3'h7;
      endcase
   endfunction

   function automatic int page_bits(input int kbit);
      page_bits = (kbit == 1) ? 3 : 4;
   endfunction

endpackage

/* File: rtl/seri_line_filter.sv */
// Purpose: two-flop synchroniser and glitch filter for one bus line
// Assumes: line idles high
// Notes:   output moves only after the synced level holds FILT_LEN samples
`timescale 1ns/1ps
module seri_line_filter (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic clk_en,
   input  wire logic line_in,
   output logic      line_out
);

   typedef struct packed {
      logic       meta;
      logic       sync;
      logic [1:0] cnt;
      logic       level;
   } seri_filt_t;

   seri_filt_t r_r;
   seri_filt_t r_nxt;

   // ======================================================
   // filter
   // sync then filter
   always_comb begin
      r_nxt      = r_r;
      r_nxt.meta = line_in;
      r_nxt.sync = r_r.meta;
      if (r_r.sync != r_r.level) begin
         if (r_r.cnt == seri_pkg::FILT_LEN - 2'h1) begin
            r_nxt.level = r_r.sync;
            r_nxt.cnt   = 2'h0;
         end else begin
            r_nxt.cnt = r_r.cnt + 2'h1;
         end
      end else begin
         r_nxt.cnt = 2'h0;
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r_r <= '{meta: 1'b1, sync: 1'b1, cnt: 2'h0, level: 1'b1};
      end else if (clk_en) begin
         r_r <= r_nxt;
      end
   end

   assign line_out = r_r.level;

   property p_filter_stable;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      (r_r.level != $past(r_r.level)) |-> ($past(r_r.sync, 2) == r_r.level);
   endproperty
   a_filter_stable: assert property (p_filter_stable)
      else $error("filter passed a short pulse");

endmodule

/* File: rtl/seri_write_timer.sv */
// Purpose: self-timed write cycle counter
// Assumes: start is a one-cycle pulse on ref_clk
// Notes:   busy stays high for exactly CYCLES enabled cycles
`timescale 1ns/1ps
module seri_write_timer #(
   parameter int CYCLES = seri_pkg::WR_CYCLES
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic clk_en,
   input  wire logic start,
   output logic      busy
);

   localparam int CW = $clog2(CYCLES + 1);

   typedef struct packed {
      logic          busy;
      logic [CW-1:0] cnt;
   } seri_tmr_t;

   seri_tmr_t r_r;
   seri_tmr_t r_nxt;

   // ======================================================
   // countdown
   // bounded write cycle
   always_comb begin
      r_nxt = r_r;
      if (start) begin
         r_nxt.busy = 1'b1;
         r_nxt.cnt  = CW'(CYCLES - 1);
      end else if (r_r.busy) begin
         if (r_r.cnt == '0) begin
            r_nxt.busy = 1'b0;
         end else begin
            r_nxt.cnt = r_r.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r_r <= '0;
      end else if (clk_en) begin
         r_r <= r_nxt;
      end
   end

   assign busy = r_r.busy;

   property p_start_busy;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      start |=> busy;
   endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("write cycle did not start");

   property p_wr_bound;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      busy |-> (r_r.cnt < CW'(CYCLES));
   endproperty
   a_wr_bound: assert property (p_wr_bound)
      else $error("write cycle count out of range");

   property p_busy_end;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      $fell(busy) |-> ($past(r_r.cnt) == '0);
   endproperty
   a_busy_end: assert property (p_busy_end)
      else $error("write cycle ended early");

endmodule

/* File: rtl/seri_eeprom_slave.sv */
// Purpose: two-wire bus slave with byte memory, page buffer and write protect
// Assumes: bus master drives scl; lines sampled on ref_clk
// Notes:   straps and wp are pins; pad pull-downs make open straps read zero
// Contract
// - write cycle ends within ten ms
// - busy: line released, address not acknowledged
// - device is slave only, master clocks
// - density parameter sets devices per bus
// - data line pulled low or released only
// - open straps read zero; smallest tied
// - used straps depend on density
// - write protect high makes array read-only
// - data change with clock high is condition
// - start is fall with clock high
// - stop is rise with clock high
// - slave address top nibble must be 1010
// - unused select bits become upper address
// - address bit zero selects read
// - acknowledge match, then read or write
// - receiver holds line low ninth clock
// - acknowledge every written byte
// - send eight bits, release, sample acknowledge
// - no master acknowledge: wait for stop
// - first written byte loads address pointer
// - protected: acknowledge addresses, not data
`timescale 1ns/1ps
module seri_eeprom_slave #(
   parameter int DENSITY_KBIT = seri_pkg::DENSITY_DEFAULT,
   parameter int WR_CYCLES    = seri_pkg::WR_CYCLES
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic clk_en,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe,
   input  wire logic device_select_strap_0,
   input  wire logic device_select_strap_1,
   input  wire logic device_select_strap_2,
   input  wire logic write_protect,
   output logic      write_busy
);

   localparam int         AW    = seri_pkg::addr_width(DENSITY_KBIT);
   localparam int         PB    = seri_pkg::page_bits(DENSITY_KBIT);
   localparam logic [2:0] SMASK = seri_pkg::sel_mask(DENSITY_KBIT);

   typedef struct packed {
      logic [2:0]            strap_m;
      logic [2:0]            strap_s;
      logic                  wp_m;
      logic                  wp_s;
      logic                  scl_p;
      logic                  sda_p;
      seri_pkg::seri_state_t st;
      logic [3:0]            cnt;
      logic [7:0]            sh;
      logic                  rw;
      logic                  addr_phase;
      logic                  macked;
      logic                  sda_oe;
      logic [2:0]            sel;
      logic [AW-1:0]         ptr;
      logic [15:0][7:0]      pb;
      logic [15:0]           pbv;
      logic                  commit;
   } seri_main_t;

   seri_main_t r_r;
   seri_main_t r_nxt;
   logic [7:0] mem [0:(1<<AW)-1];
   logic       scl_f;
   logic       sda_f;
   logic       tmr_busy;
   logic       busy_any;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;
   logic       addr_ok;
   logic [7:0] mem_rd;
   logic [10:0] full_addr;

   // ======================================================
   // line conditioning
   seri_line_filter u_scl (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .clk_en   (clk_en),
      .line_in  (scl_in),
      .line_out (scl_f)
   );

   seri_line_filter u_sda (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .clk_en   (clk_en),
      .line_in  (sda_in),
      .line_out (sda_f)
   );

   // ======================================================
   // write cycle timer
   seri_write_timer #(
      .CYCLES (WR_CYCLES)
   ) u_tmr (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clk_en  (clk_en),
      .start   (r_r.commit),
      .busy    (tmr_busy)
   );

   // ======================================================
   // bus conditions and decode
   assign busy_any = tmr_busy | r_r.commit;
   assign scl_rise = scl_f & ~r_r.scl_p;
   assign scl_fall = ~scl_f & r_r.scl_p;
   // start is falling data, clock high
   assign start_det = scl_f & r_r.scl_p & r_r.sda_p & ~sda_f;
   // stop is rising data, clock high
   assign stop_det  = scl_f & r_r.scl_p & ~r_r.sda_p & sda_f;
   assign addr_ok  = (r_r.sh[7:seri_pkg::SA_TYPE_LO] == seri_pkg::TYPE_CODE) &&
                     (((r_r.sh[seri_pkg::SA_SEL_HI:seri_pkg::SA_SEL_LO] ^ r_r.strap_s) & SMASK) == 3'h0);
   // unused select bits are upper address
   assign full_addr = {r_r.sel, r_r.sh};
   assign mem_rd    = mem[r_r.ptr];

   // ======================================================
   // main controller
   always_comb begin
      logic load_tx;
      load_tx = 1'b0;
      r_nxt   = r_r;
      r_nxt.commit  = 1'b0;
      // straps synchronised, open pads read zero
      r_nxt.strap_m = {device_select_strap_2, device_select_strap_1, device_select_strap_0};
      r_nxt.strap_s = r_r.strap_m;
      r_nxt.wp_m    = write_protect;
      r_nxt.wp_s    = r_r.wp_m;
      r_nxt.scl_p   = scl_f;
      r_nxt.sda_p   = sda_f;
      if (r_r.commit) begin
         r_nxt.pbv = '0;
      end
      if (stop_det) begin
         r_nxt.st     = seri_pkg::ST_IDLE;
         r_nxt.sda_oe = 1'b0;
         r_nxt.commit = |r_r.pbv;
      end else if (start_det && !busy_any) begin
         r_nxt.st     = seri_pkg::ST_ADDR;
         r_nxt.cnt    = 4'h0;
         r_nxt.sda_oe = 1'b0;
      end else begin
         case (r_r.st)
            seri_pkg::ST_ADDR: begin
               if (scl_rise) begin
                  r_nxt.sh  = {r_r.sh[6:0], sda_f};
                  r_nxt.cnt = r_r.cnt + 4'h1;
               end
               if (scl_fall && r_r.cnt == seri_pkg::BYTE_BITS) begin
                  if (addr_ok && !busy_any) begin
                     r_nxt.sda_oe     = 1'b1;
                     r_nxt.rw         = r_r.sh[seri_pkg::SA_RW];
                     r_nxt.addr_phase = ~r_r.sh[seri_pkg::SA_RW];
                     r_nxt.sel        = r_r.sh[seri_pkg::SA_SEL_HI:seri_pkg::SA_SEL_LO];
                     r_nxt.st         = seri_pkg::ST_ACK;
                  end else begin
                     r_nxt.st = seri_pkg::ST_WAIT;
                  end
               end
            end
            seri_pkg::ST_ACK: begin
               if (scl_fall) begin
                  r_nxt.sda_oe = 1'b0;
                  r_nxt.cnt    = 4'h0;
                  if (r_r.rw) begin
                     load_tx = 1'b1;
                  end else begin
                     r_nxt.st = seri_pkg::ST_WRX;
                  end
               end
            end
            seri_pkg::ST_WRX: begin
               if (scl_rise) begin
                  r_nxt.sh  = {r_r.sh[6:0], sda_f};
                  r_nxt.cnt = r_r.cnt + 4'h1;
               end
               if (scl_fall && r_r.cnt == seri_pkg::BYTE_BITS) begin
                  if (r_r.addr_phase) begin
                     r_nxt.ptr        = full_addr[AW-1:0];
                     r_nxt.addr_phase = 1'b0;
                     r_nxt.sda_oe     = 1'b1;
                     r_nxt.st         = seri_pkg::ST_ACK;
                  end else if (r_r.wp_s) begin
                     r_nxt.st = seri_pkg::ST_WAIT;
                  end else begin
                     r_nxt.pb[4'(r_r.ptr[PB-1:0])]  = r_r.sh;
                     r_nxt.pbv[4'(r_r.ptr[PB-1:0])] = 1'b1;
                     r_nxt.ptr[PB-1:0]              = r_r.ptr[PB-1:0] + 1'b1;
                     r_nxt.sda_oe                   = 1'b1;
                     r_nxt.st                       = seri_pkg::ST_ACK;
                  end
               end
            end
            seri_pkg::ST_TX: begin
               // shift out eight bits then release
               if (scl_fall) begin
                  if (r_r.cnt == seri_pkg::LAST_TX) begin
                     r_nxt.sda_oe = 1'b0;
                     r_nxt.macked = 1'b0;
                     r_nxt.st     = seri_pkg::ST_MACK;
                  end else begin
                     r_nxt.sh     = {r_r.sh[6:0], 1'b0};
                     r_nxt.sda_oe = ~r_r.sh[6];
                     r_nxt.cnt    = r_r.cnt + 4'h1;
                  end
               end
            end
            seri_pkg::ST_MACK: begin
               if (scl_rise) begin
                  r_nxt.macked = ~sda_f;
               end
               if (scl_fall) begin
                  if (r_r.macked) begin
                     r_nxt.cnt = 4'h0;
                     load_tx   = 1'b1;
                  end else begin
                     r_nxt.st = seri_pkg::ST_WAIT;
                  end
               end
            end
            seri_pkg::ST_IDLE, seri_pkg::ST_WAIT: begin
               r_nxt.sda_oe = 1'b0;
            end
            default: begin
               r_nxt.st     = seri_pkg::ST_IDLE;
               r_nxt.sda_oe = 1'b0;
            end
         endcase
      end
      // fetch next byte and drive its msb
      if (load_tx) begin
         r_nxt.sh     = mem_rd;
         r_nxt.sda_oe = ~mem_rd[7];
         r_nxt.ptr    = r_r.ptr + 1'b1;
         r_nxt.st     = seri_pkg::ST_TX;
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r_r       <= '0;
         r_r.st    <= seri_pkg::ST_IDLE;
         r_r.scl_p <= 1'b1;
         r_r.sda_p <= 1'b1;
      end else if (clk_en) begin
         r_r <= r_nxt;
      end
   end

   // ======================================================
   // array programming at end of write
   // only unprotected bytes reach the array
   always_ff @(posedge ref_clk) begin
      if (clk_en && !rst && r_r.commit) begin
         for (int i = 0; i < (1 << PB); i++) begin
            if (r_r.pbv[i]) begin
               mem[{r_r.ptr[AW-1:PB], PB'(i)}] <= r_r.pb[i];
            end
         end
      end
   end

   // open drain, only low or released
   assign sda_out    = 1'b0;
   assign sda_oe     = r_r.sda_oe;
   assign write_busy = busy_any;

   // ======================================================
   // assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst || !clk_en);

   property p_busy_quiet;
      busy_any |-> !r_r.sda_oe;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("line driven during write cycle");

   property p_drive_zero;
      (r_r.st == seri_pkg::ST_TX && r_r.sda_oe) |-> !r_r.sh[7];
   endproperty
   a_drive_zero: assert property (p_drive_zero)
      else $error("line pulled low for a one bit");

   property p_idle_hold;
      (r_r.st == seri_pkg::ST_IDLE && !start_det) |=> (r_r.st == seri_pkg::ST_IDLE);
   endproperty
   a_idle_hold: assert property (p_idle_hold)
      else $error("left idle without start");

   property p_stop_idle;
      stop_det |=> (r_r.st == seri_pkg::ST_IDLE && !r_r.sda_oe);
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("stop not honoured");

   property p_type_reject;
      (r_r.st == seri_pkg::ST_ADDR && scl_fall && r_r.cnt == seri_pkg::BYTE_BITS &&
       r_r.sh[7:seri_pkg::SA_TYPE_LO] != seri_pkg::TYPE_CODE) |=> (r_r.st == seri_pkg::ST_WAIT && !r_r.sda_oe);
   endproperty
   a_type_reject: assert property (p_type_reject)
      else $error("wrong type code acknowledged");

   property p_addr_ack;
      (r_r.st == seri_pkg::ST_ADDR && scl_fall && r_r.cnt == seri_pkg::BYTE_BITS && addr_ok && !busy_any)
      |=> (r_r.st == seri_pkg::ST_ACK && r_r.sda_oe && r_r.rw == $past(r_r.sh[0]));
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("matching address not acknowledged");

   property p_ack_held;
      (r_r.st == seri_pkg::ST_ACK) |-> r_r.sda_oe;
   endproperty
   a_ack_held: assert property (p_ack_held)
      else $error("acknowledge not held low");

   property p_wr_ack;
      (r_r.st == seri_pkg::ST_WRX && scl_fall && r_r.cnt == seri_pkg::BYTE_BITS && !r_r.wp_s)
      |=> (r_r.st == seri_pkg::ST_ACK && r_r.sda_oe);
   endproperty
   a_wr_ack: assert property (p_wr_ack)
      else $error("written byte not acknowledged");

   property p_tx_release;
      (r_r.st == seri_pkg::ST_TX && scl_fall && r_r.cnt == seri_pkg::LAST_TX)
      |=> (r_r.st == seri_pkg::ST_MACK && !r_r.sda_oe);
   endproperty
   a_tx_release: assert property (p_tx_release)
      else $error("line not released after eight bits");

   property p_nack_wait;
      (r_r.st == seri_pkg::ST_MACK && scl_fall && !r_r.macked) |=> (r_r.st == seri_pkg::ST_WAIT && !r_r.sda_oe);
   endproperty
   a_nack_wait: assert property (p_nack_wait)
      else $error("kept sending after no acknowledge");

   property p_ptr_load;
      (r_r.st == seri_pkg::ST_WRX && scl_fall && r_r.cnt == seri_pkg::BYTE_BITS && r_r.addr_phase)
      |=> (r_r.ptr == $past(full_addr[AW-1:0]));
   endproperty
   a_ptr_load: assert property (p_ptr_load)
      else $error("byte address not loaded");

   property p_wp_block;
      (r_r.st == seri_pkg::ST_WRX && scl_fall && r_r.cnt == seri_pkg::BYTE_BITS && !r_r.addr_phase && r_r.wp_s)
      |=> (r_r.st == seri_pkg::ST_WAIT && !r_r.sda_oe && r_r.pbv == $past(r_r.pbv));
   endproperty
   a_wp_block: assert property (p_wp_block)
      else $error("protected data accepted");

   c_read_ack: cover property (r_r.st == seri_pkg::ST_MACK && scl_fall && r_r.macked);
   c_commit:   cover property (r_r.commit);
   c_wp_nack:  cover property (r_r.st == seri_pkg::ST_WRX && scl_fall && r_r.cnt == seri_pkg::BYTE_BITS
                               && !r_r.addr_phase && r_r.wp_s);

endmodule

/* File: verif/seri_master_model.sv */
// Purpose: behavioural two-wire bus master driving the memory slave
// Assumes: data wire is open drain with pull-up, resolved in the bench
// Notes:   a bit is six cycles low, four high (80 ns); changes land on ref_clk falling edges
`timescale 1ns/1ps
module seri_master_model #(
   parameter int Q = 5
) (
   input  wire logic ref_clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_pull
);
   localparam int LO = 3;   // half of the clock low phase
   localparam int HI = 4;   // clock high phase
   // ======================================================
   // bus idles released
   initial begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic start();
      sda_pull = 1'b0;
      hold(2 * Q);
      scl = 1'b1;
      hold(Q);
      sda_pull = 1'b1;
      hold(Q);
      scl = 1'b0;
   endtask

   task automatic stop();
      sda_pull = 1'b1;
      hold(2 * Q);
      scl = 1'b1;
      hold(Q);
      sda_pull = 1'b0;
      hold(2 * Q);
   endtask

   // data moves only while clock low
   task automatic bit_x(input logic b, output logic r);
      hold(LO);
      sda_pull = ~b;
      hold(LO);
      scl = 1'b1;
      hold(HI);
      r   = sda;
      scl = 1'b0;
   endtask

   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(b[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask

   task automatic rd_byte(input logic mack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
      bit_x(~mack, r);
   endtask
endmodule

/* File: verif/seri_eeprom_slave_test.sv */
// Purpose: self-checking bench for the two-wire memory slave
// Assumes: 4 kbit density, so straps 2 and 1 compare, bit 1 is address bit 8
// Notes:   write cycle shortened to 200 cycles
`timescale 1ns/1ps
module seri_eeprom_slave_test;
   logic       ref_clk = 1'b0;
   logic       rst     = 1'b1;
   logic [2:0] strap   = 3'h0;
   logic       wp      = 1'b0;
   logic       clk_en  = 1'b1;
   logic       scl;
   logic       m_pull;
   logic       sda_out;
   logic       sda_oe;
   logic       write_busy;
   wire        sda_w   = ~((sda_oe & ~sda_out) | m_pull);
   int         mem[int];
   int         n_fail  = 0;
   int         num_checks = 0;

   // ======================================================
   // clock, device and master
   always #4 ref_clk = ~ref_clk;

   seri_eeprom_slave #(.DENSITY_KBIT(4), .WR_CYCLES(200)) i_dut (
      .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe(sda_oe), .device_select_strap_0(strap[0]),
      .device_select_strap_1(strap[1]), .device_select_strap_2(strap[2]),
      .write_protect(wp), .write_busy(write_busy));

   seri_master_model i_mst (.ref_clk(ref_clk), .sda(sda_w), .scl(scl), .sda_pull(m_pull));

   // ======================================================
   // compares and verdict
   task automatic chk_bit(input logic got, input logic exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   function automatic logic [7:0] sa(input int a, input logic rw);
      sa = {4'ha, strap[2:1], a[8], rw};
   endfunction

   // ======================================================
   // bus sequences
   task automatic probe(input logic [7:0] s, input logic exp);
      logic ack;
      i_mst.start();
      i_mst.wr_byte(s, ack);
      chk_bit(ack, exp, "address match");
      i_mst.stop();
   endtask

   task automatic write_seq(input int a, input int n);
      logic ack;
      int   d;
      int   cnt;
      i_mst.start();
      i_mst.wr_byte(sa(a, 1'b0), ack);
      chk_bit(ack, 1'b1, "write addr ack");
      i_mst.wr_byte(8'(a), ack);
      chk_bit(ack, 1'b1, "byte addr ack");
      for (int i = 0; i < n; i++) begin
         d = $urandom & 255;
         i_mst.wr_byte(8'(d), ack);
         chk_bit(ack, ~wp, "data ack");
         if (!wp) mem[(a & 496) | ((a + i) & 15)] = d;
      end
      i_mst.stop();
      i_mst.hold(8);
      chk_bit(write_busy, ~wp, "busy after stop");
      // clock enable low holds the write cycle
      clk_en = 1'b0;
      i_mst.hold(300);
      chk_bit(write_busy, ~wp, "busy frozen");
      clk_en = 1'b1;
      if (!wp) begin
         probe(sa(a, 1'b0), 1'b0);
         cnt = 0;
         while (write_busy === 1'b1 && cnt < 200) begin
            i_mst.hold(1);
            cnt++;
         end
         chk_bit(write_busy, 1'b0, "busy ends in time");
         probe(sa(a, 1'b0), 1'b1);
      end
   endtask

   task automatic read_seq(input int a, input int n);
      logic       ack;
      logic [7:0] b;
      i_mst.start();
      i_mst.wr_byte(sa(a, 1'b0), ack);
      i_mst.wr_byte(8'(a), ack);
      i_mst.start();
      i_mst.wr_byte(sa(a, 1'b1), ack);
      chk_bit(ack, 1'b1, "read addr ack");
      for (int i = 0; i < n; i++) begin
         i_mst.rd_byte(i < n - 1, b);
         chk_byte(b, 8'(mem[(a + i) & 511]), "read data");
      end
      i_mst.rd_byte(1'b0, b);
      chk_byte(b, 8'hff, "silent after nack");
      i_mst.stop();
   endtask

   // ======================================================
   // main sequence
   initial begin
      void'($urandom(3949));
      repeat (20) @(negedge ref_clk);
      rst = 1'b0;
      i_mst.hold(50);
      for (int s = 0; s < 2; s++) begin
         strap = {s[0], ~s[0], 1'($urandom)};
         probe({4'hb, strap[2:1], 2'h0}, 1'b0);
         probe({4'ha, ~strap[2], strap[1], 2'h0}, 1'b0);
         probe({4'ha, strap[2:1], 1'b1, 1'b0}, 1'b1);
         $display("address test %0d done", s);
      end
      write_seq(270, 3);
      read_seq(270, 2);
      read_seq(256, 1);
      $display("page write test done");
      wp = 1'b1;
      write_seq(271, 1);
      wp = 1'b0;
      read_seq(271, 1);
      $display("protect test done");
      begin
         int a;
         a = $urandom & 511;
         write_seq(a, 1);
         read_seq(a, 1);
      end
      $display("random test done");
      conclude();
   end

   // hang guard
   initial begin
      #300000;
      n_fail++;
      $display("MISMATCH %0t watchdog expired", $time);
      conclude();
   end
endmodule
